// ### rtl/smsb_cfg.svh
`ifndef SMSB_CFG_SVH
`define SMSB_CFG_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define SMSB_ADR_PRE_TOTAL 32'h25080420
`define SMSB_ADR_POST_TOTAL 32'h25080520
`define SMSB_ADR_IN_RATE 32'h25080c10
`define SMSB_ADR_GEAR_RATE 32'h25080d10
`define SMSB_ADR_PRI_ALARM 32'h26010010
`define SMSB_ADR_SEC_ALARM 32'h26020010
`define SMSB_ADR_STATUS 32'h60410010
`define SMSB_ADR_MODE 32'h60610008
`define SMSB_ADR_POS 32'h60630020
`define SMSB_ADR_FOLLOW 32'h60fb0820
`define SMSB_ADR_DOUT_EFF 32'h20101410
`define SMSB_ADR_DOUT_SIM 32'h20101500
`define SMSB_ADR_DOUT_POL 32'h20101504
// ****************************************
// Reset values
// ****************************************
`define SMSB_RST_WORD 32'h00000000
`define SMSB_RST_HALF 16'h0000
`define SMSB_RST_MODE 8'h00
`define SMSB_RST_POL 7'h7f
// ****************************************
// Primary alarm bit positions
// ****************************************
`define SMSB_P_EXT 0
`define SMSB_P_ENC_NC 1
`define SMSB_P_ENC_INT 2
`define SMSB_P_ENC_CRC 3
`define SMSB_P_DRV_TEMP 4
`define SMSB_P_HI_VOLT 5
`define SMSB_P_LO_VOLT 6
`define SMSB_P_OVER_CUR 7
`define SMSB_P_BRAKE 8
`define SMSB_P_POS_ERR 9
`define SMSB_P_LOGIC_UV 10
`define SMSB_P_PULSE_HI 12
`define SMSB_P_MOT_TEMP 13
`define SMSB_P_ENC_INFO 14
`define SMSB_P_NVM 15
`define SMSB_P_RSVD 11
// ****************************************
// Secondary alarm bit positions
// ****************************************
`define SMSB_S_LO 0
`define SMSB_S_LO_HI 5
`define SMSB_S_RSVD_LO 6
`define SMSB_S_RSVD_HI 7
`define SMSB_S_HI 8
`define SMSB_S_TOP 15
// ****************************************
// Timing
// ****************************************
`define SMSB_CLK_NS 25
`define SMSB_MS_NS 1000000
`endif

// ### rtl/smsb_pkg.sv
package smsb_pkg;
   typedef logic [31:0] smsb_word_t;
   typedef logic [15:0] smsb_half_t;
   typedef logic [7:0] smsb_byte_t;
endpackage

// ### rtl/smsb_top.sv
// Function
// - Effective output bit = (state OR simulation) XOR NOT polarity, outputs 1-7 on bits 0-6
// - Primary alarm word is 16-bit read-only; bit 0 flags secondary-word errors
// - Primary bits 1,2,3: encoder absent, encoder internal fault, encoder CRC error
// - Primary bits 4,5,6: drive over-temperature, high voltage, low voltage
// - Primary bits 7,8: overcurrent and brake resistor fault
// - Primary bits 9,10,12,13: position error, logic undervoltage, pulse rate, motor heat
// - Primary bits 14,15: encoder information error and nonvolatile storage alarm
// - Secondary word read-only; bits 0-3 current sensor, watchdog, interrupt, identity
// - Secondary bits 4,5,8: motor configuration, logic output, pre-enable errors
// - Secondary bits 9-12: positive limit, negative limit, serial peripheral, fieldbus
// - Secondary bits 13-15: closed loop direction, master quadrature, master count
// - Status word 16-bit read-only; buffered mode 8-bit read-only, resets to zero
// - Actual position is a read-only signed 32-bit value, reset zero
// - Following error is a read-only signed 32-bit value, reset zero
// - Pre-gear pulse total: signed 32-bit counter, readable and writable, reset zero
// - Post-gear pulse total: signed 32-bit counter, readable and writable, reset zero
// - Input pulse rate in pulses per millisecond, read-only signed 16-bit
// - Post-gear pulse rate in pulses per millisecond, read-only signed 16-bit
`timescale 1ns/1ps
`include "smsb_cfg.svh"
`default_nettype none
module smsb_top #(
   parameter int DOUT_W = 7,
   parameter int MS_CYCLES = `SMSB_MS_NS / `SMSB_CLK_NS
) (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [DOUT_W-1:0] DOUT_STATE,
   output logic [DOUT_W-1:0] DOUT_EFF,
   input wire logic [15:0] PRI_COND,
   input wire logic [15:0] SEC_COND,
   input wire logic [15:0] STATUS_WORD,
   input wire logic [7:0] OP_MODE,
   input wire logic [31:0] POS_ACTUAL,
   input wire logic [31:0] POS_FOLLOW_ERR,
   input wire logic PRE_PULSE_UP,
   input wire logic PRE_PULSE_DN,
   input wire logic POST_PULSE_UP,
   input wire logic POST_PULSE_DN
);
   localparam int MS_W = $clog2(MS_CYCLES + 1);

   // ****************************************
   // Decode helpers
   // ****************************************
   // Any address that reads back
   function automatic logic smsb_mapped(input logic [31:0] a);
      if (a == `SMSB_ADR_PRE_TOTAL || a == `SMSB_ADR_POST_TOTAL) begin
         smsb_mapped = 1'b1;
      end else if (a == `SMSB_ADR_IN_RATE || a == `SMSB_ADR_GEAR_RATE) begin
         smsb_mapped = 1'b1;
      end else if (a == `SMSB_ADR_PRI_ALARM || a == `SMSB_ADR_SEC_ALARM) begin
         smsb_mapped = 1'b1;
      end else if (a == `SMSB_ADR_STATUS || a == `SMSB_ADR_MODE) begin
         smsb_mapped = 1'b1;
      end else if (a == `SMSB_ADR_POS || a == `SMSB_ADR_FOLLOW) begin
         smsb_mapped = 1'b1;
      end else if (a == `SMSB_ADR_DOUT_EFF) begin
         smsb_mapped = 1'b1;
      end else begin
         smsb_mapped = smsb_writable(a);
      end
   endfunction

   // Only the two totals and the output controls accept writes
   function automatic logic smsb_writable(input logic [31:0] a);
      if (a == `SMSB_ADR_PRE_TOTAL || a == `SMSB_ADR_POST_TOTAL) begin
         smsb_writable = 1'b1;
      end else if (a == `SMSB_ADR_DOUT_SIM || a == `SMSB_ADR_DOUT_POL) begin
         smsb_writable = 1'b1;
      end else begin
         smsb_writable = 1'b0;
      end
   endfunction

   // Clamp a 32-bit signed delta into signed 16 bits
   function automatic smsb_pkg::smsb_half_t smsb_sat16(input logic [31:0] d);
      if ($signed(d) > $signed(32'h00007fff)) begin
         smsb_sat16 = 16'h7fff;
      end else if ($signed(d) < $signed(32'hffff8000)) begin
         smsb_sat16 = 16'h8000;
      end else begin
         smsb_sat16 = d[15:0];
      end
   endfunction

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta_q;
   logic rst_n_q;

   // Asserts at once, releases after two edges
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ****************************************
   // Bus slave
   // ****************************************
   logic setup;
   logic wr_fire;
   logic [31:0] rd_d;
   logic [DOUT_W-1:0] sim_q;
   logic [DOUT_W-1:0] pol_q;
   smsb_pkg::smsb_word_t cnt_q [2];
   smsb_pkg::smsb_half_t rate_q [2];
   smsb_pkg::smsb_half_t pri_q;
   smsb_pkg::smsb_half_t sec_q;
   smsb_pkg::smsb_half_t stat_q;
   smsb_pkg::smsb_byte_t mode_q;
   smsb_pkg::smsb_word_t pos_q;
   smsb_pkg::smsb_word_t ferr_q;

   assign setup = PSEL && !PENABLE;
   // Write lands on the completing edge only
   assign wr_fire = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

   // Read multiplexer, narrow values zero-extended
   always_comb begin
      rd_d = 32'h00000000;
      if (PADDR == `SMSB_ADR_PRE_TOTAL) begin
         rd_d = cnt_q[0];
      end else if (PADDR == `SMSB_ADR_POST_TOTAL) begin
         rd_d = cnt_q[1];
      end else if (PADDR == `SMSB_ADR_IN_RATE) begin
         rd_d[15:0] = rate_q[0];
      end else if (PADDR == `SMSB_ADR_GEAR_RATE) begin
         rd_d[15:0] = rate_q[1];
      end else if (PADDR == `SMSB_ADR_PRI_ALARM) begin
         rd_d[15:0] = pri_q;
      end else if (PADDR == `SMSB_ADR_SEC_ALARM) begin
         rd_d[15:0] = sec_q;
      end else if (PADDR == `SMSB_ADR_STATUS) begin
         rd_d[15:0] = stat_q;
      end else if (PADDR == `SMSB_ADR_MODE) begin
         rd_d[7:0] = mode_q;
      end else if (PADDR == `SMSB_ADR_POS) begin
         rd_d = pos_q;
      end else if (PADDR == `SMSB_ADR_FOLLOW) begin
         rd_d = ferr_q;
      end else if (PADDR == `SMSB_ADR_DOUT_EFF) begin
         rd_d[DOUT_W-1:0] = DOUT_EFF;
      end else if (PADDR == `SMSB_ADR_DOUT_SIM) begin
         rd_d[DOUT_W-1:0] = sim_q;
      end else if (PADDR == `SMSB_ADR_DOUT_POL) begin
         rd_d[DOUT_W-1:0] = pol_q;
      end
   end

   // One wait-free access: answer prepared in the setup cycle
   always_ff @(posedge CLOCK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= `SMSB_RST_WORD;
      end else if (setup) begin
         PREADY <= 1'b1;
         // Writes to read-only words are refused, not silently dropped
         PSLVERR <= PWRITE ? !smsb_writable(PADDR) : !smsb_mapped(PADDR);
         PRDATA <= PWRITE ? `SMSB_RST_WORD : rd_d;
      end else begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // ****************************************
   // Digital output effective state
   // ****************************************
   // Software controls of simulation and polarity
   always_ff @(posedge CLOCK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sim_q <= '0;
         pol_q <= `SMSB_RST_POL;
      end else if (wr_fire && PADDR == `SMSB_ADR_DOUT_SIM) begin
         sim_q <= PWDATA[DOUT_W-1:0];
      end else if (wr_fire && PADDR == `SMSB_ADR_DOUT_POL) begin
         pol_q <= PWDATA[DOUT_W-1:0];
      end
   end

   // Polarity reset high keeps outputs equal to state after reset
   always_ff @(posedge CLOCK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         DOUT_EFF <= '0;
      end else begin
         DOUT_EFF <= (DOUT_STATE | sim_q) ^ ~pol_q;
      end
   end

   // ****************************************
   // Alarm words
   // ****************************************
   smsb_pkg::smsb_half_t pri_d;
   smsb_pkg::smsb_half_t sec_d;

   // Secondary word; reserved bits forced low
   always_comb begin
      sec_d = 16'h0000;
      sec_d[3:`SMSB_S_LO] = SEC_COND[3:`SMSB_S_LO];
      sec_d[`SMSB_S_LO_HI:4] = SEC_COND[`SMSB_S_LO_HI:4];
      sec_d[`SMSB_S_HI] = SEC_COND[`SMSB_S_HI];
      sec_d[12:9] = SEC_COND[12:9];
      sec_d[`SMSB_S_TOP:13] = SEC_COND[`SMSB_S_TOP:13];
   end

   // Primary word; bit 0 summarises the secondary word
   always_comb begin
      pri_d = 16'h0000;
      pri_d[`SMSB_P_EXT] = |sec_d;
      pri_d[`SMSB_P_ENC_NC] = PRI_COND[`SMSB_P_ENC_NC];
      pri_d[`SMSB_P_ENC_INT] = PRI_COND[`SMSB_P_ENC_INT];
      pri_d[`SMSB_P_ENC_CRC] = PRI_COND[`SMSB_P_ENC_CRC];
      pri_d[`SMSB_P_DRV_TEMP] = PRI_COND[`SMSB_P_DRV_TEMP];
      pri_d[`SMSB_P_HI_VOLT] = PRI_COND[`SMSB_P_HI_VOLT];
      pri_d[`SMSB_P_LO_VOLT] = PRI_COND[`SMSB_P_LO_VOLT];
      pri_d[`SMSB_P_OVER_CUR] = PRI_COND[`SMSB_P_OVER_CUR];
      pri_d[`SMSB_P_BRAKE] = PRI_COND[`SMSB_P_BRAKE];
      pri_d[`SMSB_P_POS_ERR] = PRI_COND[`SMSB_P_POS_ERR];
      pri_d[`SMSB_P_LOGIC_UV] = PRI_COND[`SMSB_P_LOGIC_UV];
      pri_d[`SMSB_P_PULSE_HI] = PRI_COND[`SMSB_P_PULSE_HI];
      pri_d[`SMSB_P_MOT_TEMP] = PRI_COND[`SMSB_P_MOT_TEMP];
      pri_d[`SMSB_P_ENC_INFO] = PRI_COND[`SMSB_P_ENC_INFO];
      pri_d[`SMSB_P_NVM] = PRI_COND[`SMSB_P_NVM];
   end

   // Real-time words: no latching, a cleared source clears the bit
   always_ff @(posedge CLOCK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pri_q <= `SMSB_RST_HALF;
         sec_q <= `SMSB_RST_HALF;
      end else begin
         pri_q <= pri_d;
         sec_q <= sec_d;
      end
   end

   // ****************************************
   // Drive state snapshots
   // ****************************************
   // Sampled every cycle so a bus read sees one coherent value
   always_ff @(posedge CLOCK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stat_q <= `SMSB_RST_HALF;
         mode_q <= `SMSB_RST_MODE;
         pos_q <= `SMSB_RST_WORD;
         ferr_q <= `SMSB_RST_WORD;
      end else begin
         stat_q <= STATUS_WORD;
         mode_q <= OP_MODE;
         pos_q <= POS_ACTUAL;
         ferr_q <= POS_FOLLOW_ERR;
      end
   end

   // ****************************************
   // Millisecond tick
   // ****************************************
   logic [MS_W-1:0] ms_cnt_q;
   logic ms_tick_q;

   always_ff @(posedge CLOCK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ms_cnt_q <= '0;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q == MS_W'(MS_CYCLES - 1)) begin
         ms_cnt_q <= '0;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q <= ms_cnt_q + MS_W'(1);
         ms_tick_q <= 1'b0;
      end
   end

   // ****************************************
   // Gear pulse totals and rates
   // ****************************************
   logic [1:0] up;
   logic [1:0] dn;
   logic [1:0] ld;
   smsb_pkg::smsb_word_t last_q [2];

   assign up = {POST_PULSE_UP, PRE_PULSE_UP};
   assign dn = {POST_PULSE_DN, PRE_PULSE_DN};
   assign ld[0] = wr_fire && PADDR == `SMSB_ADR_PRE_TOTAL;
   assign ld[1] = wr_fire && PADDR == `SMSB_ADR_POST_TOTAL;

   for (genvar g = 0; g < 2; g++) begin : g_gear
      smsb_pkg::smsb_word_t base;
      smsb_pkg::smsb_word_t step;
      assign base = ld[g] ? PWDATA : cnt_q[g];
      assign step = (up[g] && !dn[g]) ? 32'h00000001 :
                    (dn[g] && !up[g]) ? 32'hffffffff : 32'h00000000;

      // A pulse in the write cycle is added to the new value, not lost
      always_ff @(posedge CLOCK or negedge rst_n_q) begin
         if (!rst_n_q) begin
            cnt_q[g] <= `SMSB_RST_WORD;
         end else begin
            cnt_q[g] <= base + step;
         end
      end

      // Rate is the counted movement over the last whole millisecond
      always_ff @(posedge CLOCK or negedge rst_n_q) begin
         if (!rst_n_q) begin
            last_q[g] <= `SMSB_RST_WORD;
            rate_q[g] <= `SMSB_RST_HALF;
         end else if (ld[g]) begin
            // Overwrite reloads the baseline only; the tick runs on, so no false jump shows
            last_q[g] <= PWDATA;
         end else if (ms_tick_q) begin
            last_q[g] <= cnt_q[g];
            rate_q[g] <= smsb_sat16(cnt_q[g] - last_q[g]);
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   dout_eff_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ##1 DOUT_EFF == $past((DOUT_STATE | sim_q) ^ ~pol_q))
      else $error("effective output mismatch");

   ext_error_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ##1 pri_q[`SMSB_P_EXT] == (|sec_q))
      else $error("extension bit disagrees with secondary word");

   enc_bits_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ##1 pri_q[3:1] == $past(PRI_COND[3:1]))
      else $error("encoder alarm bits wrong");

   power_bits_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      $rose(PRI_COND[`SMSB_P_HI_VOLT]) |=> pri_q[`SMSB_P_HI_VOLT])
      else $error("high voltage bit missed");

   current_bits_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ##1 pri_q[8:7] == $past(PRI_COND[8:7]))
      else $error("current or brake bit wrong");

   motion_bits_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ##1 {pri_q[13:12], pri_q[10:9]} == $past({PRI_COND[13:12], PRI_COND[10:9]}))
      else $error("motion alarm bits wrong");

   store_bits_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ##1 pri_q[15:14] == $past(PRI_COND[15:14]))
      else $error("encoder info or storage bit wrong");

   sec_word_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ##1 {sec_q[15:8], sec_q[5:0]} == $past({SEC_COND[15:8], SEC_COND[5:0]}))
      else $error("secondary alarm word wrong");

   rsvd_zero_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      !pri_q[`SMSB_P_RSVD] && sec_q[`SMSB_S_RSVD_HI:`SMSB_S_RSVD_LO] == 2'b00)
      else $error("reserved alarm bit set");

   alarm_clear_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      $fell(SEC_COND[`SMSB_S_TOP]) |=> !sec_q[`SMSB_S_TOP])
      else $error("alarm bit latched");

   snap_pos_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ##1 pos_q == $past(POS_ACTUAL) && ferr_q == $past(POS_FOLLOW_ERR))
      else $error("position snapshot stale");

   cnt_step_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      PRE_PULSE_UP && !PRE_PULSE_DN && !ld[0] |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1)
      else $error("pre-gear total missed a pulse");

   cnt_load_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      ld[1] && up[1] == dn[1] |=> cnt_q[1] == $past(PWDATA))
      else $error("post-gear total not overwritten");

   rate_hold_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      !ms_tick_q |=> $stable(rate_q[0]) && $stable(rate_q[1]))
      else $error("rate changed off the millisecond tick");

   ro_refuse_a: assert property (@(posedge CLOCK) disable iff (!rst_n_q)
      setup && PWRITE && PADDR == `SMSB_ADR_MODE |=> PREADY && PSLVERR ##1 !PREADY)
      else $error("write to read-only word not refused");
endmodule
`default_nettype wire

// ### testbench/tb_servo_monitor_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "smsb_cfg.svh"
module tb_servo_monitor_status_bank;
   typedef struct {smsb_pkg::smsb_word_t data; logic err;} smsb_exp_t;
   // ****************************************
   // Signals and design
   // ****************************************
   // Short rate window keeps the pulse-rate checks to a few dozen cycles
   localparam int MS = 16;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [6:0] dout_state = 7'h0;
   logic [6:0] dout_eff;
   logic [15:0] pri_cond = 16'h0, sec_cond = 16'h0, status_word = 16'h0;
   logic [7:0] op_mode = 8'h0;
   logic [31:0] pos_actual = 32'h0, pos_err = 32'h0;
   logic pre_up = 1'b0, pre_dn = 1'b0, post_up = 1'b0, post_dn = 1'b0;
   smsb_exp_t exp_q[$];
   smsb_exp_t got_e;
   smsb_pkg::smsb_word_t radr [13];
   smsb_pkg::smsb_word_t rmask [13];
   int miscompares = 0;
   int checks = 0;
   int seed = 19449;

   // Free-running 40 MHz clock
   always #12.5 clock = ~clock;

   smsb_top #(.MS_CYCLES(MS)) smsb_top_inst (
      .CLOCK(clock), .NRST(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .DOUT_STATE(dout_state), .DOUT_EFF(dout_eff), .PRI_COND(pri_cond),
      .SEC_COND(sec_cond), .STATUS_WORD(status_word), .OP_MODE(op_mode),
      .POS_ACTUAL(pos_actual), .POS_FOLLOW_ERR(pos_err), .PRE_PULSE_UP(pre_up),
      .PRE_PULSE_DN(pre_dn), .POST_PULSE_UP(post_up), .POST_PULSE_DN(post_dn)
   );
   // ****************************************
   // Tasks
   // ****************************************
   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task stop_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One APB transfer; the note goes in first so the monitor can pair it
   task apb(input logic wr, input smsb_pkg::smsb_word_t adr, input smsb_pkg::smsb_word_t wd,
            input smsb_pkg::smsb_word_t ex, input logic er);
      smsb_exp_t e;
      e.data = ex;
      e.err = er;
      exp_q.push_back(e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      // Wait as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task rd(input smsb_pkg::smsb_word_t adr, input smsb_pkg::smsb_word_t ex);
      apb(1'b0, adr, 32'h0, ex, 1'b0);
   endtask

   // Direct compare on a level output
   task chk(input logic [31:0] got, input logic [31:0] ex);
      checks++;
      if (got !== ex) begin
         miscompares++;
         $display("unexpected at %0t: port %h want %h", $time, got, ex);
      end
   endtask

   task set_pulse(input logic post, input logic up, input logic dn);
      if (post) begin
         post_up <= up;
         post_dn <= dn;
      end else begin
         pre_up <= up;
         pre_dn <= dn;
      end
   endtask
   // ****************************************
   // Checking and sequence
   // ****************************************
   // Pairs each completed transfer with the oldest note
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1) begin
         checks++;
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("unexpected at %0t: stray transfer", $time);
         end else begin
            got_e = exp_q.pop_front();
            if (prdata !== got_e.data || pslverr !== got_e.err) begin
               miscompares++;
               $display("unexpected at %0t: addr %h got %h/%b want %h/%b", $time, paddr,
                        prdata, pslverr, got_e.data, got_e.err);
            end
         end
      end
   end

   // Watchdog sized well above the roughly 750 cycles the tests need
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      $display("unexpected at %0t: watchdog", $time);
      stop_test();
   end

   // Main sequence
   initial begin
      logic [31:0] w;
      logic [6:0] st, sim, pol, ex;
      radr = '{`SMSB_ADR_IN_RATE, `SMSB_ADR_GEAR_RATE, `SMSB_ADR_PRI_ALARM,
               `SMSB_ADR_SEC_ALARM, `SMSB_ADR_STATUS, `SMSB_ADR_MODE, `SMSB_ADR_POS,
               `SMSB_ADR_FOLLOW, `SMSB_ADR_DOUT_EFF, `SMSB_ADR_PRE_TOTAL,
               `SMSB_ADR_POST_TOTAL, `SMSB_ADR_DOUT_SIM, `SMSB_ADR_DOUT_POL};
      rmask = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                32'hffffffff, 32'hffffffff, 32'h7f, 32'h7f};
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      cyc(3);
      chk({25'h0, dout_eff}, 32'h0);
      // Reset value, then a write that only the writable words accept
      for (int i = 0; i < 13; i++) begin
         w = $random(seed);
         rd(radr[i], (i == 12) ? 32'h7f : 32'h0);
         apb(1'b1, radr[i], w, 32'h0, rmask[i] == 32'h0);
         rd(radr[i], w & rmask[i]);
      end
      apb(1'b0, 32'h0, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 32'h25080424, 32'h5, 32'h0, 1'b1);
      $display("test access done");
      for (int i = 0; i < 8; i++) begin
         st = 7'($random(seed));
         sim = 7'($random(seed));
         pol = (i == 0) ? 7'h0 : 7'($random(seed));
         apb(1'b1, `SMSB_ADR_DOUT_SIM, {25'h0, sim}, 32'h0, 1'b0);
         apb(1'b1, `SMSB_ADR_DOUT_POL, {25'h0, pol}, 32'h0, 1'b0);
         dout_state <= st;
         cyc(3);
         ex = (st | sim) ^ ~pol;
         rd(`SMSB_ADR_DOUT_EFF, {25'h0, ex});
         chk({25'h0, dout_eff}, {25'h0, ex});
      end
      $display("test outputs done");
      // Walking one through each alarm source, cleared between steps
      for (int i = 0; i < 16; i++) begin
         pri_cond <= 16'h1 << i;
         sec_cond <= 16'h0;
         cyc(2);
         rd(`SMSB_ADR_PRI_ALARM, (i == 0 || i == 11) ? 32'h0 : 32'h1 << i);
         pri_cond <= 16'h0;
         sec_cond <= 16'h1 << i;
         cyc(2);
         rd(`SMSB_ADR_SEC_ALARM, (i == 6 || i == 7) ? 32'h0 : 32'h1 << i);
         rd(`SMSB_ADR_PRI_ALARM, (i == 6 || i == 7) ? 32'h0 : 32'h1);
      end
      sec_cond <= 16'h0;
      $display("test alarms done");
      for (int i = 0; i < 4; i++) begin
         status_word <= 16'($random(seed));
         op_mode <= 8'($random(seed));
         pos_actual <= (i == 0) ? 32'h80000000 : $random(seed);
         pos_err <= (i == 0) ? 32'h7fffffff : $random(seed);
         cyc(2);
         rd(`SMSB_ADR_STATUS, {16'h0, status_word});
         rd(`SMSB_ADR_MODE, {24'h0, op_mode});
         rd(`SMSB_ADR_POS, pos_actual);
         rd(`SMSB_ADR_FOLLOW, pos_err);
      end
      $display("test snapshots done");
      // Wrap across the signed boundary, then both-lines and down steps
      for (int k = 0; k < 2; k++) begin
         w = k ? `SMSB_ADR_POST_TOTAL : `SMSB_ADR_PRE_TOTAL;
         apb(1'b1, w, 32'h7ffffffe, 32'h0, 1'b0);
         set_pulse(k[0], 1'b1, 1'b0);
         cyc(3);
         set_pulse(k[0], 1'b0, 1'b0);
         cyc(1);
         rd(w, 32'h80000001);
         set_pulse(k[0], 1'b1, 1'b1);
         cyc(4);
         set_pulse(k[0], 1'b0, 1'b1);
         cyc(2);
         set_pulse(k[0], 1'b0, 1'b0);
         cyc(1);
         rd(w, 32'h7fffffff);
      end
      $display("test totals done");
      // Steady pulsing for three windows gives one count per cycle
      for (int k = 0; k < 4; k++) begin
         set_pulse(k[1], ~k[0], k[0]);
         cyc(48);
         rd(k[1] ? `SMSB_ADR_GEAR_RATE : `SMSB_ADR_IN_RATE,
            k[0] ? {16'h0, 16'(-MS)} : 32'(MS));
         set_pulse(k[1], 1'b0, 1'b0);
         cyc(1);
      end
      $display("test rates done");
      stop_test();
   end
endmodule
`default_nettype wire
